// ### hdl/dac_ovd_consts.vh
// constants for the four-channel overdrive update controller
`ifndef DAC_OVD_CONSTS_VH
`define DAC_OVD_CONSTS_VH

// ==========================================
// clocking and timebase
`define CLK_FREQ_HZ 20000000
`define CLK_PERIOD_NS 50
`define TB_FREQ_HZ 2000000
`define TB_DIV_CYCLES (`CLK_FREQ_HZ / `TB_FREQ_HZ)
`define TB_TICKS_PER_US (`TB_FREQ_HZ / 1000000)
`define GLIDE_UNIT_US 2

// ==========================================
// overdrive offset and timing
`define OVD_DELTA_MV 4000
`define STEP_LO_MV 189
`define STEP_HI_MV 220
`define OFS_CODE_LO ((`OVD_DELTA_MV + `STEP_LO_MV / 2) / `STEP_LO_MV)
`define OFS_CODE_HI ((`OVD_DELTA_MV + `STEP_HI_MV / 2) / `STEP_HI_MV)
`define OVD_NS_PER_CODE 250
`define OVD_CYC_PER_CODE ((`OVD_NS_PER_CODE + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVD_MIN_NS 1000
`define OVD_MIN_CYC ((`OVD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CODE_MAX 7'h7f

// ==========================================
// register word indexes (byte address = index * 4)
`define IDX_CFG 4'h0
`define IDX_MODE 4'h1
`define IDX_TRIG 4'h2
`define IDX_VAL_A 4'h3
`define IDX_STATUS 4'h7
`define IDX_CODE_A 4'h8
`define IDX_LAST 4'hb
`define IDX_NONE 4'hf

// ==========================================
// field positions
`define CFG_RANGE_BIT 0
`define CFG_BOOST_LSB 4
`define CFG_EN_LSB 8
`define CFG_LOWPWR_BIT 12
`define CFG_AUTOTRIG_BIT 13
`define CFG_ANTTRIG_BIT 14
`define MODE_RISE_LSB 8
`define MODE_FALL_LSB 12
`define MODE_ADJ_LSB 16
`define MODE_GLIDE_LSB 20
`define VAL_STYLE_BIT 7

// ==========================================
// reset values
`define CFG_RESET 32'h000020d0
`define MODE_RESET 32'h00003300
`define VAL_RESET 8'h80

`endif

// ### hdl/ovd_channel.v
// one output channel: direct update and autonomous overdrive sequencer
`include "dac_ovd_consts.vh"

module ovd_channel (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_trig,
    input wire i_enable,
    input wire i_low_power,
    input wire i_ovd_req,
    input wire i_step_sel,
    input wire [6:0] i_target,
    input wire [2:0] i_rise_scale,
    input wire [2:0] i_fall_scale,
    input wire [1:0] i_low_adj,
    output reg [6:0] o_code,
    output reg o_busy
);
    // ==========================================
    // state
    reg [11:0] timer_r;  // overdrive cycles left
    reg [6:0] tgt_r;     // final code held during overdrive
    reg woke_r;          // channel has been through low power
    // offset codes as 32-bit constants, trimmed below
    wire [31:0] ofs_lo_w = `OFS_CODE_LO;
    wire [31:0] ofs_hi_w = `OFS_CODE_HI;
    // ==========================================
    // offset and direction arithmetic
    wire [6:0] old_code = woke_r ? 7'h00 : o_code;
    wire rise = i_target > old_code;
    wire [6:0] diff = rise ? (i_target - old_code) : (old_code - i_target);
    wire [6:0] ofs = i_step_sel ? ofs_hi_w[6:0] : ofs_lo_w[6:0];
    wire [7:0] up_sum = {1'b0, i_target} + {1'b0, ofs};
    wire [6:0] up_code = up_sum[7] ? `CODE_MAX : up_sum[6:0];
    wire [6:0] dn_code = (i_target < ofs) ? 7'h00 : (i_target - ofs);
    wire low_tgt = i_target < ofs;  // target below the 4 V offset
    // ==========================================
    // overdrive duration
    wire [31:0] base_w = diff * `OVD_CYC_PER_CODE + `OVD_MIN_CYC;
    wire [2:0] scale = rise ? i_rise_scale : i_fall_scale;
    wire [31:0] scaled_w = (base_w * (32'd8 + scale)) >> 3;
    wire [31:0] adj_w = scaled_w + ((scaled_w * i_low_adj) >> 2);
    wire [31:0] time_w = (!rise && low_tgt) ? adj_w : scaled_w;

    // sequencer: trigger, countdown and abandon
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_code <= 7'h00;
            o_busy <= 1'b0;
            timer_r <= 12'h000;
            tgt_r <= 7'h00;
            woke_r <= 1'b0;
        end else begin
            if (i_low_power) begin
                woke_r <= 1'b1;
            end
            if (o_busy && !i_enable) begin
                // disabled mid-overdrive: settle on the target
                o_code <= tgt_r;
                o_busy <= 1'b0;
            end else if (i_trig) begin
                if (!i_low_power) begin
                    woke_r <= 1'b0;
                end
                if (o_busy) begin
                    o_code <= i_target;
                    o_busy <= 1'b0;
                end else if (i_target != old_code) begin
                    if (i_ovd_req) begin
                        o_code <= rise ? up_code : dn_code;
                        timer_r <= time_w[11:0];
                        tgt_r <= i_target;
                        o_busy <= 1'b1;
                    end else begin
                        o_code <= i_target;
                    end
                end
            end else if (o_busy) begin
                if (timer_r == 12'h000) begin
                    o_code <= tgt_r;
                    o_busy <= 1'b0;
                end else begin
                    timer_r <= timer_r - 12'h001;
                end
            end
        end
    end
endmodule

// ### hdl/glide_timer.v
// shared glide step-interval decode and tick generator
`include "dac_ovd_consts.vh"

module glide_timer (
    input wire i_clk,
    input wire i_rst_n,
    input wire [4:0] i_step,
    output reg o_tick,
    output wire [6:0] o_interval_us
);
    // ==========================================
    // decode: 2 us times (field + 1)
    function [6:0] interval_us;
        input [4:0] f;
        reg [31:0] us;  // full-width product, at most 64
        begin
            us = ({27'h0, f} + 32'h00000001) * `GLIDE_UNIT_US;
            interval_us = us[6:0];
        end
    endfunction

    wire [31:0] tb_div_w = `TB_DIV_CYCLES;
    wire [31:0] tb_per_us_w = `TB_TICKS_PER_US;
    // timebase ticks per glide step, at most 128
    wire [7:0] ticks_w = {1'b0, interval_us(i_step)} * tb_per_us_w[7:0];
    reg [3:0] pre_r;   // core clock to 2 MHz prescaler
    reg [7:0] cnt_r;   // timebase ticks in current step
    wire tb_pulse = (pre_r == tb_div_w[3:0] - 4'h1);

    assign o_interval_us = interval_us(i_step);

    // divide the core clock down to the timebase, then to the step
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_r <= 4'h0;
            cnt_r <= 8'h00;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            pre_r <= tb_pulse ? 4'h0 : pre_r + 4'h1;
            if (tb_pulse) begin
                if (cnt_r >= ticks_w - 8'h01) begin
                    cnt_r <= 8'h00;
                    o_tick <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 8'h01;
                end
            end
        end
    end
endmodule

// ### hdl/dac_overdrive_update_control.v
// top: APB registers, trigger sources and four overdrive channels
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`include "dac_ovd_consts.vh"

module dac_overdrive_update_control (
    input wire I_CORE_CLK,
    input wire I_RESET_N,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire I_ANT_SEL,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    output wire [6:0] O_CODE_A,
    output wire [6:0] O_CODE_B,
    output wire [6:0] O_CODE_C,
    output wire [6:0] O_CODE_D,
    output reg [3:0] O_DRIVE_EN,
    output wire [3:0] O_STEP_SEL,
    output wire O_RANGE_SEL,
    output wire [3:0] O_BOOST_CODE,
    output wire O_GLIDE_TICK,
    output wire [3:0] O_BUSY
);
    // ==========================================
    // reset release
    reg rst_meta_r;  // first stage, read only by second
    reg rst_n_r;     // released reset used everywhere

    // two-stage release of the asynchronous reset
    always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ==========================================
    // address decode
    // word index for a byte address, none when unmapped
    function [3:0] reg_sel;
        input [11:0] a;
        begin
            if (a[11:6] != 6'h00 || a[1:0] != 2'b00) begin
                reg_sel = `IDX_NONE;
            end else if (a[5:2] > `IDX_LAST) begin
                reg_sel = `IDX_NONE;
            end else begin
                reg_sel = a[5:2];
            end
        end
    endfunction

    // ==========================================
    // registers
    reg [31:0] cfg_r;       // range, boost, enables, power, trigger sources
    reg [31:0] mode_r;      // channel modes, time scales, glide step
    reg [31:0] val_r;       // four value bytes, channel a lowest
    reg [3:0] trig_r;       // per-channel trigger, one cycle
    reg [3:0] trig_nxt;     // combined trigger sources
    reg ant_prev_r;         // pad level last cycle
    reg [31:0] rdata_nxt;   // read mux
    wire [3:0] sel = reg_sel(I_PADDR);
    wire setup = I_PSEL && !I_PENABLE;
    wire wr_go = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;  // write strobe
    wire [27:0] codes_w;    // applied codes, 7 bits each
    wire [6:0] glide_us_w;  // decoded glide interval
    wire low_power = cfg_r[`CFG_LOWPWR_BIT];
    wire [3:0] boost = cfg_r[`CFG_BOOST_LSB +: 4];
    wire [6:0] ceiling = {boost, 3'b111};  // usable top code
    wire ant_toggle = (I_ANT_SEL ^ ant_prev_r) && cfg_r[`CFG_ANTTRIG_BIT];

    assign O_RANGE_SEL = cfg_r[`CFG_RANGE_BIT];
    assign O_BOOST_CODE = boost;
    assign O_CODE_A = codes_w[6:0];
    assign O_CODE_B = codes_w[13:7];
    assign O_CODE_C = codes_w[20:14];
    assign O_CODE_D = codes_w[27:21];

    // ==========================================
    // apb access timing
    // zero-wait slave: ready in the access cycle, data registered in setup
    always @(posedge I_CORE_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            O_PREADY <= 1'b0;
            O_PSLVERR <= 1'b0;
            O_PRDATA <= 32'h00000000;
        end else begin
            O_PREADY <= setup;
            O_PSLVERR <= setup && (sel == `IDX_NONE);
            if (setup) begin
                O_PRDATA <= I_PWRITE ? 32'h00000000 : rdata_nxt;
            end
        end
    end

    // read mux, unmapped and write-only words read zero
    always @* begin
        rdata_nxt = 32'h00000000;
        case (sel)
            `IDX_CFG: begin
                rdata_nxt = cfg_r;
            end
            `IDX_MODE: begin
                rdata_nxt = mode_r;
            end
            4'h3, 4'h4, 4'h5, 4'h6: begin
                rdata_nxt = {24'h000000, val_r[(sel - `IDX_VAL_A) * 8 +: 8]};
            end
            `IDX_STATUS: begin
                rdata_nxt = {9'h000, glide_us_w, 4'h0, O_DRIVE_EN, 4'h0, O_BUSY};
            end
            4'h8, 4'h9, 4'ha, 4'hb: begin
                rdata_nxt = {25'h0000000, codes_w[(sel - `IDX_CODE_A) * 7 +: 7]};
            end
            default: begin
                rdata_nxt = 32'h00000000;
            end
        endcase
    end

    // ==========================================
    // register writes
    // configuration and value storage
    always @(posedge I_CORE_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_r <= `CFG_RESET;
            mode_r <= `MODE_RESET;
            val_r <= {4{`VAL_RESET}};
        end else if (wr_go) begin
            case (sel)
                `IDX_CFG: begin
                    cfg_r <= {17'h00000, I_PWDATA[14:0]};
                end
                `IDX_MODE: begin
                    mode_r <= {7'h00, I_PWDATA[24:0]};
                end
                4'h3, 4'h4, 4'h5, 4'h6: begin
                    val_r[(sel - `IDX_VAL_A) * 8 +: 8] <= I_PWDATA[7:0];
                end
                default: begin
                    cfg_r <= cfg_r;
                end
            endcase
        end
    end

    // ==========================================
    // trigger sources
    // software word, pad toggle and post-write trigger, one cycle late
    always @* begin
        trig_nxt = ant_toggle ? 4'hf : 4'h0;
        if (wr_go && sel == `IDX_TRIG) begin
            trig_nxt = trig_nxt | I_PWDATA[3:0];
        end
        if (wr_go && sel >= `IDX_VAL_A && sel < `IDX_STATUS &&
            cfg_r[`CFG_AUTOTRIG_BIT]) begin
            case (sel)
                4'h3: begin
                    trig_nxt = trig_nxt | 4'h1;
                end
                4'h4: begin
                    trig_nxt = trig_nxt | 4'h2;
                end
                4'h5: begin
                    trig_nxt = trig_nxt | 4'h4;
                end
                default: begin
                    trig_nxt = trig_nxt | 4'h8;
                end
            endcase
        end
    end

    // trigger register and pad history
    always @(posedge I_CORE_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            trig_r <= 4'h0;
            ant_prev_r <= 1'b0;
        end else begin
            trig_r <= trig_nxt;
            ant_prev_r <= I_ANT_SEL;
        end
    end

    // ==========================================
    // output drive enables
    // pins float in reset, low power or when disabled
    always @(posedge I_CORE_CLK or negedge rst_n_r) begin
        if (!rst_n_r) begin
            O_DRIVE_EN <= 4'h0;
        end else begin
            O_DRIVE_EN <= low_power ? 4'h0 : cfg_r[`CFG_EN_LSB +: 4];
        end
    end

    // ==========================================
    // channels
    genvar c;
    generate
        for (c = 0; c < 4; c = c + 1) begin : g_chan
            wire [7:0] v = val_r[c * 8 +: 8];
            // clamp the requested code to the boost ceiling
            wire [6:0] tgt = (v[6:0] > ceiling) ? ceiling : v[6:0];
            // style bit low and the channel's overdrive mode bit set in mode_r
            wire req = !v[`VAL_STYLE_BIT] && mode_r[2 * c + 1];
            assign O_STEP_SEL[c] = mode_r[2 * c];
            ovd_channel u_chan (
                .i_clk(I_CORE_CLK),
                .i_rst_n(rst_n_r),
                .i_trig(trig_r[c]),
                .i_enable(cfg_r[`CFG_EN_LSB + c]),
                .i_low_power(low_power),
                .i_ovd_req(req),
                .i_step_sel(mode_r[2 * c]),
                .i_target(tgt),
                .i_rise_scale(mode_r[`MODE_RISE_LSB +: 3]),
                .i_fall_scale(mode_r[`MODE_FALL_LSB +: 3]),
                .i_low_adj(mode_r[`MODE_ADJ_LSB +: 2]),
                .o_code(codes_w[c * 7 +: 7]),
                .o_busy(O_BUSY[c])
            );
        end
    endgenerate

    // ==========================================
    // glide step timing
    glide_timer u_glide (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n_r),
        .i_step(mode_r[`MODE_GLIDE_LSB +: 5]),
        .o_tick(O_GLIDE_TICK),
        .o_interval_us(glide_us_w)
    );
endmodule

// ### testbench/dac_ovd_chk.sv
// concurrent checks on the overdrive controller's register port and outputs
module dac_ovd_chk (
    input wire I_CORE_CLK,
    input wire I_RESET_N,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire O_PREADY,
    input wire O_PSLVERR,
    input wire [6:0] O_CODE_A,
    input wire [3:0] O_DRIVE_EN,
    input wire [3:0] O_STEP_SEL,
    input wire O_RANGE_SEL,
    input wire [3:0] O_BOOST_CODE,
    input wire O_GLIDE_TICK,
    input wire [3:0] O_BUSY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    // ==========================================
    // completed write access
    wire wr_acc = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
    a_ready_pulse: assert property (I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY)
        else $error("ready not a single access cycle");
    a_ready_cause: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
        else $error("ready outside access");
    a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
    a_unmapped_err: assert property (I_PSEL && !I_PENABLE && I_PADDR > 12'h02c |=> O_PSLVERR)
        else $error("unmapped address accepted");
    a_range_follow: assert property (
        wr_acc && I_PADDR == 12'h000 |=> O_RANGE_SEL == $past(I_PWDATA[0]))
        else $error("range select not taken");
    a_boost_follow: assert property (
        wr_acc && I_PADDR == 12'h000 |=> O_BOOST_CODE == $past(I_PWDATA[7:4]))
        else $error("boost code not taken");
    a_low_power_off: assert property (
        wr_acc && I_PADDR == 12'h000 && I_PWDATA[12] |-> ##[1:3] O_DRIVE_EN == 4'h0)
        else $error("outputs driven in low power");
    a_step_follow: assert property (
        wr_acc && I_PADDR == 12'h004 |=> O_STEP_SEL == {$past(I_PWDATA[6]),
        $past(I_PWDATA[4]), $past(I_PWDATA[2]), $past(I_PWDATA[0])})
        else $error("step select not taken");
    a_offset_hold: assert property (
        O_BUSY[0] && $past(O_BUSY[0]) |-> $stable(O_CODE_A))
        else $error("code moved during overdrive");
    a_tick_gap: assert property (O_GLIDE_TICK |=> (!O_GLIDE_TICK) [*8])
        else $error("glide ticks too close");
    // main scenarios reached
    c_busy: cover property ($rose(O_BUSY[0]));
    c_err: cover property (O_PSLVERR);
    c_tick: cover property (O_GLIDE_TICK);
endmodule

bind dac_overdrive_update_control dac_ovd_chk chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_CODE_A(O_CODE_A),
    .O_DRIVE_EN(O_DRIVE_EN), .O_STEP_SEL(O_STEP_SEL), .O_RANGE_SEL(O_RANGE_SEL),
    .O_BOOST_CODE(O_BOOST_CODE), .O_GLIDE_TICK(O_GLIDE_TICK), .O_BUSY(O_BUSY)
);

// ### testbench/apb_host.sv
// host-side apb master model that drives the controller's register port
module apb_host (
    input wire logic clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic to);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        to = (pready !== 1'b1);
        // released address and data show the inverse, never the old value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the four-channel overdrive update controller
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, ant_sel, psel, penable, pwrite, pready, pslverr, range_sel, tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] code_a, code_b, code_c, code_d;
    logic [3:0] drive_en, step_sel, boost, busy;
    int bad_count = 0;
    int check_count = 0;
    // ==========================================
    // clock, design and host model
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    dac_overdrive_update_control uut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_ANT_SEL(ant_sel), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_CODE_A(code_a), .O_CODE_B(code_b), .O_CODE_C(code_c), .O_CODE_D(code_d),
        .O_DRIVE_EN(drive_en),
        .O_STEP_SEL(step_sel), .O_RANGE_SEL(range_sel), .O_BOOST_CODE(boost),
        .O_GLIDE_TICK(tick), .O_BUSY(busy));
    apb_host host (.clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // ==========================================
    // helpers
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic fail_out();
        bad_count++;
        tally_and_finish();
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        logic t;
        host.xfer(w, a, d, r, e, t);
        if (t) fail_out();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic xe,
                          input string what);
        logic [31:0] r;
        logic e;
        bus(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
        chk(e, xe, "pslverr");
    endtask
    // overdrive length in cycles, offset phase included
    function automatic int hold(int diff, int sc, int adj, bit lowfall);
        int t;
        t = (diff * 5 + 20) * (8 + sc) / 8;
        if (lowfall) t = t + t * adj / 4;
        return t + 1;
    endfunction
    // style bit clear: offset code first, then the target
    task automatic ovd(input logic [6:0] tgt, input logic [6:0] ofs, input int len,
                       input bit full);
        int n;
        n = 0;
        wr(12'h00c, {25'h0, tgt});
        do begin
            cyc(1);
            n++;
        end while (busy[0] !== 1'b1 && n < 20);
        if (n >= 20) fail_out();
        chk(code_a, ofs, "offset code");
        if (full) begin
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (busy[0] === 1'b1 && n < 3000);
            chk(n, len, "hold cycles");
            chk(code_a, tgt, "final code");
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        logic [31:0] dm [2];
        logic [31:0] dv [2];
        int n;
        dm = '{32'h00003303, 32'h00003301};
        dv = '{32'h00000090, 32'h00000020};
        rst_n = 1'b0;
        ant_sel = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(12'h000, 32'h000020d0, 1'b0, "cfg");
        rd_chk(12'h004, 32'h00003300, 1'b0, "mode");
        rd_chk(12'h00c, 32'h00000080, 1'b0, "val a");
        rd_chk(12'h030, 32'h0, 1'b1, "unmapped");
        chk(boost, 4'hd, "boost");
        chk(drive_en, 4'h0, "drive en");
        wr(12'h000, 32'h000021d1);
        wr(12'h004, 32'h00003302);
        cyc(2);
        chk(range_sel, 1'b1, "range");
        chk(drive_en, 4'h1, "drive en");
        ovd(7'd40, 7'd61, hold(40, 3, 0, 0), 1'b1);
        wr(12'h004, 32'h00011302);
        ovd(7'd5, 7'd0, hold(35, 1, 1, 1), 1'b1);
        wr(12'h00c, 32'h00000005);
        cyc(6);
        chk({busy, 1'b0, code_a}, {4'h0, 1'b0, 7'd5}, "equal code");
        wr(12'h000, 32'h000021f1);
        wr(12'h004, 32'h00003303);
        cyc(2);
        chk(step_sel, 4'h1, "step sel");
        ovd(7'd120, 7'd127, 0, 1'b0);
        wr(12'h00c, 32'h00000050);
        cyc(3);
        chk({busy, 1'b0, code_a}, {4'h0, 1'b0, 7'd80}, "retrigger");
        for (int i = 0; i < 2; i++) begin
            wr(12'h004, dm[i]);
            wr(12'h00c, dv[i]);
            cyc(4);
            chk({busy, 1'b0, code_a}, {4'h0, 1'b0, dv[i][6:0]}, "direct");
        end
        wr(12'h000, 32'h000041f1);
        wr(12'h00c, 32'h00000090);
        cyc(4);
        chk(code_a, 7'd32, "no auto trigger");
        wr(12'h008, 32'h00000001);
        cyc(3);
        chk(code_a, 7'd16, "sw trigger");
        // channels b to d get codes 3, 5, 7 that only the pad toggle applies
        for (int k = 1; k < 4; k++) begin
            wr(12'h00c + 12'(4 * k), 32'h00000081 + 2 * k);
        end
        wr(12'h00c, 32'h00000085);
        @(posedge clk);
        ant_sel <= 1'b1;
        cyc(4);
        chk(code_a, 7'd5, "pad trigger");
        chk({code_d, code_c, code_b}, {7'd7, 7'd5, 7'd3}, "pad trigger bcd");
        rd_chk(12'h024, 32'h00000003, 1'b0, "code b");
        for (int s = 0; s < 5; s += 4) begin
            wr(12'h004, 32'h00003301 | (s << 20));
            rd_chk(12'h01c, 32'h00000100 | ((2 * (s + 1)) << 16), 1'b0, "status");
            repeat (2) begin
                n = 0;
                do begin
                    cyc(1);
                    n++;
                end while (tick !== 1'b1 && n < 2000);
                if (n >= 2000) fail_out();
            end
            chk(n, 40 * (s + 1), "tick gap");
        end
        wr(12'h000, 32'h000051f1);
        cyc(3);
        chk(drive_en, 4'h0, "low power");
        // leaving low power: old code counts as zero, so 5 -> 5 still overdrives
        wr(12'h004, 32'h00003302);
        wr(12'h000, 32'h000021f1);
        ovd(7'd5, 7'd26, hold(5, 3, 0, 0), 1'b1);
        tally_and_finish();
    end
endmodule
